// file: dv/btc_host_model.sv
// Host side of the register strobe port: byte writes and reads.
// Assumes the bench calls its tasks one at a time from a single process.
module btc_host_model (
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // codes are not masked: the whole byte goes out; set point codes are six bits wide.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output bit ok);
    int i;
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    ok = 1'b0;
    d  = 8'h00;
    for (i = 0; i < 4 && !ok; i++) begin
      #1;
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata;
      end else begin
        @(posedge mclk);
      end
    end
  endtask

  // Write, then read the same register on the very next cycle.
  task automatic write_read(input logic [7:0] a, input logic [7:0] d,
                            output logic [7:0] q, output bit ok);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1;
    ok = (reg_rvalid === 1'b1);
    q  = reg_rdata;
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the second buck regulator register bank.
// Assumes the host model drives the strobe port; the bench drives the rest.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import btc_pkg::*;

  logic        mclk, rst_n, cfg_load, cfg_range;
  btc_pstate_t pwr_state;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, reg_rvalid, code_reserved;
  logic [6:0]  active_code;
  logic [11:0] active_mv;
  logic [3:0]  mode_sel;
  logic        regulator_off, pfm_run, ilim;
  logic [1:0]  freq, phase, speed;
  int          failures, tests_run;

  btc_host_model host (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  btc_regs dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cfg_load(cfg_load),
    .cfg_range(cfg_range), .pwr_state(pwr_state),
    .active_code(active_code), .active_mv(active_mv),
    .code_reserved(code_reserved), .switching_mode_select(mode_sel),
    .regulator_off(regulator_off), .pfm_run(pfm_run),
    .current_limit_select(ilim), .switch_frequency_select(freq),
    .phase_clock_select(phase), .voltage_ramp_speed(speed));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
               got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    host.read_reg(a, d, ok);
    if (!ok) begin
      failures++;
      final_report();
    end else begin
      chk({4'h0, d}, {4'h0, exp}, "register read");
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    rd(BTC_ADDR_NORMAL, 8'h00);
    rd(BTC_ADDR_STANDBY, 8'h00);
    rd(BTC_ADDR_SLEEP, 8'h00);
    rd(BTC_ADDR_MODE, 8'h08);
    rd(BTC_ADDR_CONFIG, 8'h00);
    chk(active_mv, 12'd400, "reset level");
    $display("test_reset done");
  endtask

  task automatic test_masks;
    logic [7:0] exp [5] = '{8'h3F, 8'h3F, 8'h3F, 8'h2F, 8'hFF};
    for (int i = 0; i < 5; i++) host.write_reg(8'h35 + 8'(i), 8'hFF);
    for (int i = 0; i < 5; i++) rd(8'h35 + 8'(i), exp[i]);
    chk(12'(mode_sel), 12'h00F, "mode output");
    host.write_reg(BTC_ADDR_MODE, 8'h00);
    rd(BTC_ADDR_MODE, 8'h00);
    $display("test_masks done");
  endtask

  task automatic test_states;
    logic [5:0]  code [3] = '{6'h05, 6'h0A, 6'h3F};
    logic [11:0] mv [3]   = '{12'd525, 12'd650, 12'd1975};
    for (int i = 0; i < 3; i++)
      host.write_reg(8'h35 + 8'(i), {2'b00, code[i]});
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk) pwr_state <= btc_pstate_t'(i);
      settle(2);
      chk({5'h00, active_code}, {6'h00, code[i]}, "active code");
      chk(active_mv, mv[i], "active level");
      chk(12'({regulator_off, pfm_run}), 12'({i == 2, 1'b0}), "off");
    end
    host.write_reg(BTC_ADDR_MODE, 8'h20);
    settle(2);
    chk(12'({regulator_off, pfm_run}), 12'h001, "sleep pulse run");
    $display("test_states done");
  endtask

  task automatic test_range;
    @(posedge mclk) cfg_load <= 1'b1;
    cfg_range <= 1'b1;
    @(posedge mclk) cfg_load <= 1'b0;
    host.write_reg(BTC_ADDR_NORMAL, 8'h00);
    rd(BTC_ADDR_NORMAL, 8'h40);
    rd(BTC_ADDR_STANDBY, 8'h4A);
    rd(BTC_ADDR_SLEEP, 8'h7F);
    host.write_reg(BTC_ADDR_SLEEP, 8'h32);
    settle(2);
    chk(active_mv, 12'd3300, "top level");
    chk(12'(code_reserved), 12'h000, "last valid code");
    host.write_reg(BTC_ADDR_SLEEP, 8'h33);
    settle(2);
    chk(12'(code_reserved), 12'h001, "reserved code");
    $display("test_range done");
  endtask

  task automatic test_config;
    host.write_reg(BTC_ADDR_CONFIG, 8'h9D);
    rd(BTC_ADDR_CONFIG, 8'h9D);
    chk(12'(ilim), 12'h001, "current limit");
    chk(12'(freq), 12'h003, "frequency");
    chk(12'(phase), 12'h001, "phase");
    chk(12'(speed), 12'h002, "ramp speed");
    host.write_reg(8'h3A, 8'hFF);
    rd(8'h3A, 8'h00);
    $display("test_config done");
  endtask

  task automatic test_write_read;
    logic [7:0] d;
    bit         ok;
    host.write_read(BTC_ADDR_NORMAL, 8'hEA, d, ok);
    chk(12'(ok), 12'h001, "back to back valid");
    chk({4'h0, d}, 12'h06A, "back to back read");
    $display("test_write_read done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    failures  = 0;
    tests_run = 0;
    rst_n     = 1'b0;
    cfg_load  = 1'b0;
    cfg_range = 1'b0;
    pwr_state = BTC_NORMAL;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    test_reset();
    test_masks();
    test_states();
    test_range();
    test_config();
    test_write_read();
    final_report();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    final_report();
  end
endmodule

// file: logic/btc_dec_if.sv
// Carries one set point code to the level decoder and the level back.
// Assumes both ends sit in the same clock domain.
interface btc_dec_if;
  logic [5:0]  code;
  logic        range;
  logic [11:0] mv;
  logic        reserved;

  modport user    (output code, output range, input mv, input reserved);
  modport decoder (input code, input range, output mv, output reserved);
endinterface

// file: logic/btc_pkg.sv
// Constants shared by the second buck regulator control registers.
// Assumes an I2C slave elsewhere turns bus transfers into register strobes.
package btc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] BTC_ADDR_NORMAL  = 8'h35;
  localparam logic [7:0] BTC_ADDR_STANDBY = 8'h36;
  localparam logic [7:0] BTC_ADDR_SLEEP   = 8'h37;
  localparam logic [7:0] BTC_ADDR_MODE    = 8'h38;
  localparam logic [7:0] BTC_ADDR_CONFIG  = 8'h39;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int         BTC_CODE_W      = 6;
  localparam int         BTC_RANGE_BIT   = 6;
  localparam int         BTC_MODE_W      = 4;
  localparam int         BTC_OMODE_BIT   = 5;
  localparam int         BTC_ILIM_BIT    = 0;
  localparam int         BTC_FREQ_LSB    = 2;
  localparam int         BTC_PHASE_LSB   = 4;
  localparam int         BTC_SPEED_LSB   = 6;
  localparam int         BTC_FIELD2_W    = 2;
  localparam logic [5:0] BTC_CODE_RST    = 6'h00;
  localparam logic [3:0] BTC_MODE_RST    = 4'h8;
  localparam logic [7:0] BTC_CONFIG_RST  = 8'h00;
  localparam logic [7:0] BTC_UNMAPPED_RD = 8'h00;

  // ****************************************************************
  // Output level in millivolts per code step
  // ****************************************************************
  localparam int         BTC_MV_W        = 12;
  localparam int         BTC_MV_LO_BASE  = 400;
  localparam int         BTC_MV_LO_STEP  = 25;
  localparam int         BTC_MV_HI_BASE  = 800;
  localparam int         BTC_MV_HI_STEP  = 50;
  localparam logic [5:0] BTC_HI_LAST_OK  = 6'h32;

  typedef enum logic [1:0] {
    BTC_NORMAL,
    BTC_STANDBY,
    BTC_SLEEP
  } btc_pstate_t;

endpackage

// file: logic/btc_regs.sv
// Control register bank of the second buck regulator.
// Assumes the I2C slave gives one-cycle read and write strobes on mclk.
//
// How it works
// R1: Register 0x35 keeps a writable six-bit normal set point, reset to zero.
// R2: The range bit of 0x35 is read-only and loads only at start-up config.
// R3: Register 0x36 keeps a writable six-bit standby set point, reset zero.
// R4: Bit 6 of 0x36 and 0x37 reads back the same start-up range bit.
// R5: Register 0x37 keeps a writable six-bit sleep set point, reset to zero.
// R6: Register 0x38 keeps a writable four-bit mode code reset to 0x08.
// R7: Bit 5 of 0x38 picks off (0) or pulse-frequency run (1) in sleep.
// R8: Bit 0 of 0x39 selects the high (0) or low (1) current limit.
// R9: Bits 3:2 of 0x39 select the switching frequency, reset zero.
// R10: Bits 5:4 of 0x39 select the switching clock phase, reset zero.
// R11: Bits 7:6 of 0x39 select the voltage ramp speed, reset zero.
// R12: The host writes only codes 0 to 63 in the low range below 2.0 V.
// R13: Level is 400 mV + 25 mV/step, or 800 mV + 50 mV/step to code 114.
// R14: Unused bits of the set point and mode registers read zero.
module btc_regs (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic                  cfg_load,
  input  wire logic                  cfg_range,
  input  wire btc_pkg::btc_pstate_t  pwr_state,
  output logic      [6:0]            active_code,
  output logic      [11:0]           active_mv,
  output logic                       code_reserved,
  output logic      [3:0]            switching_mode_select,
  output logic                       regulator_off,
  output logic                       pfm_run,
  output logic                       current_limit_select,
  output logic      [1:0]            switch_frequency_select,
  output logic      [1:0]            phase_clock_select,
  output logic      [1:0]            voltage_ramp_speed
);
  import btc_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [5:0] normal_q,   normal_d;
  logic [5:0] standby_q,  standby_d;
  logic [5:0] sleep_q,    sleep_d;
  logic [3:0] mode_q,     mode_d;
  logic       omode_q,    omode_d;
  logic [7:0] config_q,   config_d;
  logic       range_q,    range_d;
  logic [7:0] rdata_d;
  logic       rvalid_d;

  always_comb begin
    normal_d  = normal_q;
    standby_d = standby_q;
    sleep_d   = sleep_q;
    mode_d    = mode_q;
    omode_d   = omode_q;
    config_d  = config_q;
    // R2: range bit has no host write path
    range_d   = cfg_load ? cfg_range : range_q;
    if (reg_wr) begin
      unique case (reg_addr)
        // R1: normal set point write
        BTC_ADDR_NORMAL:  normal_d  = reg_wdata[BTC_CODE_W-1:0];
        // R3: standby set point write
        BTC_ADDR_STANDBY: standby_d = reg_wdata[BTC_CODE_W-1:0];
        // R5: sleep set point write
        BTC_ADDR_SLEEP:   sleep_d   = reg_wdata[BTC_CODE_W-1:0];
        // R6: mode code and R7: sleep behaviour
        BTC_ADDR_MODE: begin
          mode_d  = reg_wdata[BTC_MODE_W-1:0];
          omode_d = reg_wdata[BTC_OMODE_BIT];
        end
        // R8: current limit select, R9 R10 R11: config fields
        BTC_ADDR_CONFIG:  config_d  = reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Reads are registered so data never glitches toward the I2C shifter.
  always_comb begin
    rvalid_d = reg_rd;
    rdata_d  = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        // R14: unused bits read zero, R4: range mirrored
        BTC_ADDR_NORMAL:  rdata_d = {1'b0, range_q, normal_q};
        BTC_ADDR_STANDBY: rdata_d = {1'b0, range_q, standby_q};
        BTC_ADDR_SLEEP:   rdata_d = {1'b0, range_q, sleep_q};
        BTC_ADDR_MODE:    rdata_d = {2'b00, omode_q, 1'b0, mode_q};
        BTC_ADDR_CONFIG:  rdata_d = config_q;
        default:          rdata_d = BTC_UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      normal_q   <= BTC_CODE_RST;
      standby_q  <= BTC_CODE_RST;
      sleep_q    <= BTC_CODE_RST;
      mode_q     <= BTC_MODE_RST;
      omode_q    <= 1'b0;
      config_q   <= BTC_CONFIG_RST;
      range_q    <= 1'b0;
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      normal_q   <= normal_d;
      standby_q  <= standby_d;
      sleep_q    <= sleep_d;
      mode_q     <= mode_d;
      omode_q    <= omode_d;
      config_q   <= config_d;
      range_q    <= range_d;
      reg_rdata  <= rdata_d;
      reg_rvalid <= rvalid_d;
    end
  end

  // ****************************************************************
  // Regulator controls
  // ****************************************************************
  btc_dec_if dec ();

  btc_setpoint_decode u_decode (
    .dec (dec)
  );

  logic [5:0]  sel_code;
  logic [6:0]  act_code_d;
  logic        off_d;
  logic        pfm_d;

  // R4: all three states share the start-up range bit
  always_comb begin
    off_d = 1'b0;
    pfm_d = 1'b0;
    unique case (pwr_state)
      BTC_NORMAL:  sel_code = normal_q;
      BTC_STANDBY: sel_code = standby_q;
      BTC_SLEEP: begin
        sel_code = sleep_q;
        // R7: sleep behaviour
        off_d    = !omode_q;
        pfm_d    = omode_q;
      end
      default:     sel_code = normal_q;
    endcase
    act_code_d = {range_q, sel_code};
  end

  assign dec.code  = sel_code;
  assign dec.range = range_q;

  // The decoded level lags the state change by one cycle; the analog
  // ramp is far slower, so this costs nothing and keeps outputs clean.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_code   <= 7'h00;
      active_mv     <= 12'h000;
      code_reserved <= 1'b0;
      regulator_off <= 1'b0;
      pfm_run       <= 1'b0;
    end else begin
      active_code   <= act_code_d;
      active_mv     <= dec.mv;
      code_reserved <= dec.reserved;
      regulator_off <= off_d;
      pfm_run       <= pfm_d;
    end
  end

  // R8: R9: R10: R11: fields straight from flops
  assign switching_mode_select   = mode_q;
  assign current_limit_select    = config_q[BTC_ILIM_BIT];
  assign switch_frequency_select = config_q[BTC_FREQ_LSB +: BTC_FIELD2_W];
  assign phase_clock_select      = config_q[BTC_PHASE_LSB +: BTC_FIELD2_W];
  assign voltage_ramp_speed      = config_q[BTC_SPEED_LSB +: BTC_FIELD2_W];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_normal_write: assert property ( // R1
    reg_wr && reg_addr == BTC_ADDR_NORMAL ##1 reg_rd && !reg_wr &&
    reg_addr == BTC_ADDR_NORMAL |=>
    reg_rdata[5:0] == $past(reg_wdata[5:0], 2))
    else $error("normal set point did not keep the written code");
  a_range_locked: assert property ( // R2
    !cfg_load |=> range_q == $past(range_q))
    else $error("range bit changed without start-up load");
  a_standby_write: assert property ( // R3
    reg_wr && reg_addr == BTC_ADDR_STANDBY |=>
    standby_q == $past(reg_wdata[5:0]))
    else $error("standby set point not written");
  a_range_mirror: assert property ( // R4
    reg_rd && (reg_addr == BTC_ADDR_STANDBY || reg_addr == BTC_ADDR_SLEEP)
    |=> reg_rdata[6] == $past(range_q))
    else $error("range bit not mirrored");
  a_sleep_write: assert property ( // R5
    reg_wr && reg_addr == BTC_ADDR_SLEEP |=> sleep_q == $past(reg_wdata[5:0]))
    else $error("sleep set point not written");
  a_mode_write: assert property ( // R6
    reg_wr && reg_addr == BTC_ADDR_MODE |=>
    switching_mode_select == $past(reg_wdata[3:0]))
    else $error("mode code not written");
  a_sleep_action: assert property ( // R7
    pwr_state == BTC_SLEEP |=> regulator_off == !$past(omode_q) &&
    pfm_run == $past(omode_q))
    else $error("sleep behaviour wrong");
  a_config_write: assert property ( // R8
    reg_wr && reg_addr == BTC_ADDR_CONFIG |=>
    {voltage_ramp_speed, phase_clock_select, switch_frequency_select,
     config_q[1], current_limit_select} == $past(reg_wdata))
    else $error("config fields not written");
  a_level_map: assert property ( // R13
    rst_n && pwr_state == BTC_NORMAL |=> active_mv == ($past(range_q) ?
    BTC_MV_W'(BTC_MV_HI_BASE + BTC_MV_HI_STEP * int'($past(normal_q))) :
    BTC_MV_W'(BTC_MV_LO_BASE + BTC_MV_LO_STEP * int'($past(normal_q)))))
    else $error("level decode wrong");
  a_unused_zero: assert property ( // R14
    reg_rd && reg_addr >= BTC_ADDR_NORMAL && reg_addr <= BTC_ADDR_MODE
    |=> reg_rdata[7] == 1'b0 && (reg_addr != BTC_ADDR_MODE ||
    (reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0)))
    else $error("unused bit read nonzero");

  c_range_load:  cover property (cfg_load && cfg_range ##1 range_q);
  c_sleep_pfm:   cover property (pwr_state == BTC_SLEEP && omode_q ##1 pfm_run);
  c_reserved:    cover property (code_reserved);
  c_write_read:  cover property (reg_wr ##1 reg_rd ##1 reg_rvalid);

endmodule

// file: logic/btc_setpoint_decode.sv
// Maps a seven-bit set point (range bit and six-bit code) to millivolts.
// Assumes the caller registers the result; purely combinational.
module btc_setpoint_decode (
  btc_dec_if.decoder dec
);
  import btc_pkg::*;

  // R13: code to level
  always_comb begin
    if (dec.range) begin
      dec.mv       = BTC_MV_W'(BTC_MV_HI_BASE +
                               BTC_MV_HI_STEP * int'(dec.code));
      dec.reserved = (dec.code > BTC_HI_LAST_OK);
    end else begin
      dec.mv       = BTC_MV_W'(BTC_MV_LO_BASE +
                               BTC_MV_LO_STEP * int'(dec.code));
      dec.reserved = 1'b0;
    end
  end

endmodule
